/* File: src/lpd_pkg.sv */
/*
 * Package for the local-to-PCI address decoder: constants, codes and
 * the request and cycle structs used by the decoder and its FIFO.
 * Assumes a single clock domain, sys_clk at 100 MHz.
 */
// Contract
// (RQ1) Claim every access in bridge 256 MB block
// (RQ2) Address bits 30:28 select top-level space
// (RQ3) Reset map: fixed regions, untranslated memory passthrough
// (RQ4) Byte 0000 0xxx gives 64 kB I/O cycles
// (RQ5) 100x config address, 101x config data
// (RQ6) 110x own registers, 1110 special, 1111 intack
// (RQ7) Config data low bits match config address
// (RQ8) Fixed map lowest megabyte; else passthrough memory
// (RQ9) Two memory windows, one I/O window compared
// (RQ10) Window size 32, 64, 128 or 256 MB
// (RQ11) Priority: fixed, mem0, mem1, I/O window
// (RQ12) Memory hit address from base and masked bits
// (RQ13) Window base supplies top PCI address nibble
// (RQ14) No window hit: address sent untranslated
// (RQ15) PCI bit n is local bit 31-n
// (RQ16) Data bytes reordered to little-endian
// (RQ17) Initiator avoids looping back to own target
// (RQ18) PCI boot target answers first read
// (RQ19) Size field masks local bits 27:24
// (RQ20) Non-bridge accesses make no PCI activity
`default_nettype none
package lpd_pkg;
    localparam logic [2:0] SPACE_DRAM   = 3'h0;
    localparam logic [2:0] SPACE_CTRL   = 3'h1;
    localparam logic [2:0] SPACE_FLASH  = 3'h2;
    localparam logic [2:0] SPACE_BRIDGE = 3'h3;
    localparam logic [3:0] SIZE_32MB    = 4'h1;
    localparam logic [3:0] SIZE_64MB    = 4'h3;
    localparam logic [3:0] SIZE_128MB   = 4'h7;
    localparam logic [3:0] SIZE_256MB   = 4'hf;
    localparam logic [3:0] SIZE_RST     = 4'h0;
    localparam logic [7:0] BASE_RST     = 8'h00;
    localparam logic [7:0] LB_BASE_RST  = 8'h00;
    localparam logic       EN_RST       = 1'b0;
    localparam int         FIFO_DEPTH   = 16;

    typedef enum logic [2:0] {
        CYC_MEM, CYC_IO, CYC_CFG_ADDR, CYC_CFG_DATA,
        CYC_OWN_REG, CYC_SPECIAL, CYC_INTACK
    } lpd_cyc_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [63:0] data;
        logic [7:0]  be;
        logic        write;
    } lpd_req_t;

    typedef struct packed {
        lpd_cyc_t    kind;
        logic [31:0] pci_addr;
        logic [63:0] data;
        logic [7:0]  be;
        logic        write;
    } lpd_cyc_s_t;

    typedef struct packed {
        logic       en;
        logic [7:0] local_base;
        logic [3:0] size;
        logic [7:0] pci_base;
    } lpd_win_t;
endpackage : lpd_pkg
`default_nettype wire

/* File: src/lpd_decoder.sv */
/*
 * Address decoder and byte reorderer of the local-to-PCI bridge, with
 * the output FIFO. Assumes requests arrive on sys_clk; window settings
 * are quasi-static ports from the same domain.
 */
`default_nettype none
module lpd_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         sys_rst,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } lpd_fifo_st_t;
    lpd_fifo_st_t s_q, s_d;
    logic push, pop;

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign in_ready  = s_q.cnt != (AW+1)'(D);
    assign out_valid = s_q.cnt != '0;
    assign out_data  = s_q.mem[s_q.rp];

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wp] = in_data;
            s_d.wp = s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = s_q.rp + 1'b1;
        end
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : lpd_fifo

module lpd_decoder #(
    parameter int DEPTH = lpd_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  sys_rst,
    // Local bus request (big-endian bit numbering on addr)
    input  wire logic                  req_valid,
    output logic                       req_ready,
    input  wire lpd_pkg::lpd_req_t     req,
    // Window configuration: mem0, mem1, io
    input  wire lpd_pkg::lpd_win_t     mem_window0,
    input  wire lpd_pkg::lpd_win_t     mem_window1,
    input  wire lpd_pkg::lpd_win_t     io_window,
    // PCI cycle output
    output logic                       cyc_valid,
    input  wire logic                  cyc_ready,
    output lpd_pkg::lpd_cyc_s_t        cyc,
    // Status
    output logic                       ignored_q
);
    localparam int CW = $bits(lpd_pkg::lpd_cyc_s_t);

    typedef struct packed {
        logic                stg_valid;
        lpd_pkg::lpd_cyc_s_t stg;
        logic                ignored;
    } lpd_st_t;
    lpd_st_t s_q, s_d;

    logic [31:0]         pa;
    logic [31:0]         pa_le;
    logic [63:0]         data_le;
    logic [7:0]          be_le;
    logic                in_bridge;
    logic                fixed_hit;
    logic                hit0, hit1, hit_io;
    lpd_pkg::lpd_cyc_s_t dec;
    logic                fifo_ready;
    logic [CW-1:0]       fifo_out;

    // ****************************************************
    // Bit mirroring and byte reordering
    // ****************************************************
    genvar g;
    generate
        for (g = 0; g < 32; g++) begin : g_mirror
            assign pa[g] = req.addr[31-g]; // [RQ15]
        end
        for (g = 0; g < 8; g++) begin : g_twist
            assign data_le[g*8 +: 8] = req.data[(7-g)*8 +: 8]; // [RQ16]
            assign be_le[g] = req.be[7-g]; // [RQ16]
        end
    endgenerate
    assign pa_le = pa;

    // ****************************************************
    // Window compare
    // ****************************************************
    function automatic logic win_hit(lpd_pkg::lpd_win_t w,
                                     logic [31:0] a);
        // Set size bits exclude matching address bits
        win_hit = w.en && (((a[27:24] ^ w.local_base[3:0])
                  & ~w.size) == 4'h0); // [RQ19] [RQ10] [RQ9]
    endfunction : win_hit

    // [RQ1] [RQ2] [RQ20]
    assign in_bridge = pa[30:28] == lpd_pkg::SPACE_BRIDGE;
    // [RQ8]
    assign fixed_hit = pa[27:20] == 8'h00 && pa[19] == 1'b0
                       ? 1'b1 : (pa[27:20] == 8'h00);
    assign hit0      = win_hit(mem_window0, pa);
    assign hit1      = win_hit(mem_window1, pa);
    assign hit_io    = win_hit(io_window, pa);

    // ****************************************************
    // Decode
    // ****************************************************
    always_comb begin
        dec.data     = data_le;
        dec.be       = be_le;
        dec.write    = req.write;
        dec.kind     = lpd_pkg::CYC_MEM;
        dec.pci_addr = {4'h0, pa[27:0]}; // [RQ3] [RQ14]
        if (fixed_hit) begin // [RQ11]
            unique casez (pa[23:16])
                8'b0000_0???: begin // [RQ4]
                    dec.kind     = lpd_pkg::CYC_IO;
                    dec.pci_addr = {16'h0000, pa[15:0]};
                end
                8'b0000_100?: begin // [RQ5]
                    dec.kind     = lpd_pkg::CYC_CFG_ADDR;
                    dec.pci_addr = pa;
                end
                8'b0000_101?: begin // [RQ5]
                    dec.kind     = lpd_pkg::CYC_CFG_DATA;
                    dec.pci_addr = pa;
                end
                8'b0000_110?: begin // [RQ6]
                    dec.kind     = lpd_pkg::CYC_OWN_REG;
                    dec.pci_addr = {24'h000000, pa[7:0]};
                end
                8'b0000_1110: dec.kind = lpd_pkg::CYC_SPECIAL; // [RQ6]
                8'b0000_1111: dec.kind = lpd_pkg::CYC_INTACK; // [RQ6]
                default:      dec.kind = lpd_pkg::CYC_MEM; // [RQ8]
            endcase
        end else if (hit0) begin // [RQ11] [RQ12] [RQ13]
            dec.pci_addr = {mem_window0.pci_base[7:4],
                (pa[27:24] & ~mem_window0.size)
                | mem_window0.pci_base[3:0], pa[23:0]};
        end else if (hit1) begin // [RQ11] [RQ12] [RQ13]
            dec.pci_addr = {mem_window1.pci_base[7:4],
                (pa[27:24] & ~mem_window1.size)
                | mem_window1.pci_base[3:0], pa[23:0]};
        end else if (hit_io) begin // [RQ13]
            dec.kind     = lpd_pkg::CYC_IO;
            dec.pci_addr = {io_window.pci_base[7:4],
                (pa[27:24] & ~io_window.size)
                | io_window.pci_base[3:0], pa[23:0]};
        end
    end

    // ****************************************************
    // Stage register and FIFO
    // ****************************************************
    assign req_ready = !s_q.stg_valid || fifo_ready;

    always_comb begin
        s_d = s_q;
        s_d.ignored = 1'b0;
        if (s_q.stg_valid && fifo_ready) begin
            s_d.stg_valid = 1'b0;
        end
        if (req_valid && req_ready) begin
            if (in_bridge) begin
                s_d.stg_valid = 1'b1;
                s_d.stg       = dec;
            end else begin
                s_d.ignored = 1'b1; // [RQ20]
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    lpd_fifo #(.W(CW), .D(DEPTH)) u_fifo (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .in_valid  (s_q.stg_valid),
        .in_ready  (fifo_ready),
        .in_data   (s_q.stg),
        .out_valid (cyc_valid),
        .out_ready (cyc_ready),
        .out_data  (fifo_out)
    );
    assign cyc       = lpd_pkg::lpd_cyc_s_t'(fifo_out);
    assign ignored_q = s_q.ignored;

    // ****************************************************
    // Checks
    // ****************************************************
    property p_ignore;
        @(posedge sys_clk) disable iff (sys_rst)
        req_valid && req_ready && !in_bridge |=> ignored_q
            && !s_q.stg_valid;
    endproperty
    a_ignore: assert property (p_ignore) // [RQ20]
        else $error("Non-bridge access was staged");

    property p_claim;
        @(posedge sys_clk) disable iff (sys_rst)
        req_valid && req_ready && in_bridge |=> s_q.stg_valid;
    endproperty
    a_claim: assert property (p_claim) // [RQ1]
        else $error("Bridge access not claimed");

    property p_passthru;
        @(posedge sys_clk) disable iff (sys_rst)
        req_valid && req_ready && in_bridge && !fixed_hit && !hit0
            && !hit1 && !hit_io |=> s_q.stg.pci_addr[31:28] == 4'h0
            && s_q.stg.kind == lpd_pkg::CYC_MEM;
    endproperty
    a_passthru: assert property (p_passthru) // [RQ14]
        else $error("Passthrough address translated");

    property p_io_fixed;
        @(posedge sys_clk) disable iff (sys_rst)
        req_valid && req_ready && in_bridge && pa[27:19] == 9'h000
            |=> s_q.stg.kind == lpd_pkg::CYC_IO
            && s_q.stg.pci_addr[31:16] == 16'h0000;
    endproperty
    a_io_fixed: assert property (p_io_fixed) // [RQ4]
        else $error("Fixed I/O region misdecoded");

    property p_win0;
        @(posedge sys_clk) disable iff (sys_rst)
        req_valid && req_ready && in_bridge && !fixed_hit && hit0
            |=> s_q.stg.pci_addr[31:28] == $past(mem_window0.pci_base[7:4]);
    endproperty
    a_win0: assert property (p_win0) // [RQ13]
        else $error("Window 0 top nibble wrong");

    property p_special;
        @(posedge sys_clk) disable iff (sys_rst)
        req_valid && req_ready && in_bridge && pa[27:16] == 12'h00e
            |=> s_q.stg.kind == lpd_pkg::CYC_SPECIAL;
    endproperty
    a_special: assert property (p_special) // [RQ6]
        else $error("Special cycle not issued");

    property p_twist;
        @(posedge sys_clk) disable iff (sys_rst)
        req_valid && req_ready && in_bridge
            |=> s_q.stg.data[7:0] == $past(req.data[63:56]);
    endproperty
    a_twist: assert property (p_twist) // [RQ16]
        else $error("Data bytes not reordered");

    property p_prio;
        @(posedge sys_clk) disable iff (sys_rst)
        req_valid && req_ready && in_bridge && !fixed_hit && hit0
            && hit1 |=> s_q.stg.pci_addr[31:28]
            == $past(mem_window0.pci_base[7:4]);
    endproperty
    a_prio: assert property (p_prio) // [RQ11]
        else $error("Window 1 beat window 0");
endmodule : lpd_decoder
`default_nettype wire

/* File: verification/lpd_pci_agent.sv */
/*
 * Drain-side model of the PCI agents behind the decoder.
 * Assumes the sys_clk domain; the bench reads the got queue.
 */
`default_nettype none
module lpd_pci_agent (
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                sys_rst,
    // Pacing from the bench
    input  wire logic                hold,
    input  wire logic                slow,
    // Cycle stream
    input  wire logic                cyc_valid,
    output logic                     cyc_ready,
    input  wire lpd_pkg::lpd_cyc_s_t cyc
);
    timeunit 1ns;
    timeprecision 1ps;
    lpd_pkg::lpd_cyc_s_t got[$];
    // Ready straight after reset, no setup cycles needed
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cyc_ready <= 1'b1;
        end else begin
            cyc_ready <= !hold && (!slow || !cyc_ready);
            if (cyc_valid && cyc_ready) begin
                got.push_back(cyc);
            end
        end
    end
endmodule : lpd_pci_agent
`default_nettype wire

/* File: verification/lpd_decoder_tb_top.sv */
/*
 * Self-checking bench of lpd_decoder with a drain-side agent.
 * Assumes lpd_pkg and the design files are compiled first.
 */
`default_nettype none
module lpd_decoder_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DEPTH = 16;
    logic sys_clk, sys_rst, req_valid, req_ready, cyc_valid, cyc_ready;
    logic hold, slow, ignored_q, ok;
    lpd_pkg::lpd_req_t   req;
    lpd_pkg::lpd_win_t   mem_window0, mem_window1, io_window;
    lpd_pkg::lpd_cyc_s_t cyc;
    int fails, tests_run, ign_cnt, n0;

    lpd_decoder #(.DEPTH(DEPTH)) u_lpd_decoder (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .mem_window0(mem_window0),
        .mem_window1(mem_window1), .io_window(io_window),
        .cyc_valid(cyc_valid), .cyc_ready(cyc_ready), .cyc(cyc),
        .ignored_q(ignored_q));
    lpd_pci_agent u_lpd_pci_agent (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .hold(hold), .slow(slow),
        .cyc_valid(cyc_valid), .cyc_ready(cyc_ready), .cyc(cyc));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (ignored_q === 1'b1) ign_cnt++;
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] rev(input logic [31:0] v);
        for (int i = 0; i < 32; i++) rev[i] = v[31-i];
    endfunction : rev
    function automatic logic [63:0] sw(input logic [63:0] v);
        for (int i = 0; i < 8; i++) sw[8*i+:8] = v[8*(7-i)+:8];
    endfunction : sw
    function automatic logic [31:0] xl(input logic [31:0] p,
                                       input lpd_pkg::lpd_win_t w);
        return {w.pci_base[7:4], (p[27:24] & ~w.size) | w.pci_base[3:0],
                p[23:0]};
    endfunction : xl
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %0t seen %h exp %h", $time, s, e);
        end
    endtask : chk
    task automatic stop_test;
        if (fails == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    // Offer one request, give up after 20 refused cycles
    task automatic send(input logic [31:0] p, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req <= '{addr: rev(p), data: {p, ~p}, be: 8'hff, write: 1'b1};
        while (!ok && n < 20) begin
            @(negedge sys_clk);
            ok = (req_ready === 1'b1);
            n++;
        end
        @(posedge sys_clk);
        req_valid <= 1'b0;
    endtask : send
    task automatic check(input logic [31:0] p, input lpd_pkg::lpd_cyc_t k,
                         input logic [31:0] a, input logic [31:0] m);
        lpd_pkg::lpd_cyc_s_t c;
        int n;
        n = 0;
        while (u_lpd_pci_agent.got.size() == 0 && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        c = 'x;
        if (n < 200) c = u_lpd_pci_agent.got.pop_front();
        chk(64'(c.kind), 64'(k));
        chk(64'(c.pci_addr & m), 64'(a & m));
        chk(c.data, sw({p, ~p}));
    endtask : check
    task automatic sc(input logic [31:0] p, input lpd_pkg::lpd_cyc_t k,
                      input logic [31:0] a, input logic [31:0] m);
        logic f;
        send(p, f);
        check(p, k, a, m);
    endtask : sc

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_fixed;
        // Config data low bits repeat the config address ones
        logic [31:0] ps [8] = '{32'h3003a5c3, 32'h3008a5c3, 32'h300ba5c3,
            32'h300da5c3, 32'h300ea5c3, 32'h300fa5c3, 32'h3035a5c3,
            32'h3ffffffc};
        lpd_pkg::lpd_cyc_t ks [8] = '{lpd_pkg::CYC_IO,
            lpd_pkg::CYC_CFG_ADDR, lpd_pkg::CYC_CFG_DATA,
            lpd_pkg::CYC_OWN_REG, lpd_pkg::CYC_SPECIAL, lpd_pkg::CYC_INTACK,
            lpd_pkg::CYC_MEM, lpd_pkg::CYC_MEM};
        logic [31:0] ms [8] = '{32'hffff, 0, 0, 0, 0, 0, '1, '1};
        for (int i = 0; i < 8; i++) begin
            sc(ps[i], ks[i], {4'h0, ps[i][27:0]}, ms[i]);
        end
    endtask : t_fixed
    task automatic t_ignore;
        logic [31:0] ps [3] = '{32'h00000010, 32'h2ffffffc, 32'h40000000};
        for (int i = 0; i < 3; i++) begin
            n0 = ign_cnt;
            send(ps[i], ok);
            repeat (6) @(posedge sys_clk);
            chk(64'(ign_cnt - n0), 64'h1);
            chk(64'(u_lpd_pci_agent.got.size()), 64'h0);
        end
    endtask : t_ignore
    task automatic t_fifo;
        int acc;
        acc = 0;
        hold <= 1'b1;
        for (int i = 0; i < DEPTH + 3; i++) begin
            send(32'h33100000 + 32'(i << 4), ok);
            if (ok) acc++;
        end
        chk(64'(acc), 64'(DEPTH + 1));
        hold <= 1'b0;
        slow <= 1'b1;
        for (int i = 0; i < acc; i++) begin
            check(32'h33100000 + 32'(i << 4), lpd_pkg::CYC_MEM,
                  32'h03100000 + 32'(i << 4), '1);
        end
        slow <= 1'b0;
    endtask : t_fifo
    task automatic t_windows;
        // Window targets stay off the bridge's own target
        mem_window0 <= '{1'b1, 8'h05, lpd_pkg::SIZE_32MB, 8'h8a};
        mem_window1 <= '{1'b1, 8'h04, lpd_pkg::SIZE_128MB, 8'h40};
        io_window   <= '{1'b1, 8'h00, lpd_pkg::SIZE_256MB, 8'hc0};
        @(posedge sys_clk);
        sc(32'h35123450, lpd_pkg::CYC_MEM, xl(32'h35123450, mem_window0),
           '1);
        sc(32'h37123450, lpd_pkg::CYC_MEM, xl(32'h37123450, mem_window1),
           '1);
        sc(32'h39123450, lpd_pkg::CYC_IO, 32'hc0123450, '1);
        sc(32'h300e1234, lpd_pkg::CYC_SPECIAL, 0, 0);
        mem_window0.size <= lpd_pkg::SIZE_64MB;
        @(posedge sys_clk);
        sc(32'h36123450, lpd_pkg::CYC_MEM, 32'h8e123450, '1);
        mem_window0.en <= 1'b0;
        mem_window1.en <= 1'b0;
        io_window.en   <= 1'b0;
        @(posedge sys_clk);
        sc(32'h39123450, lpd_pkg::CYC_MEM, 32'h09123450, '1);
    endtask : t_windows

    initial begin
        fails = 0;
        tests_run = 0;
        ign_cnt = 0;
        sys_rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        mem_window0 = '0;
        mem_window1 = '0;
        io_window = '0;
        hold = 1'b0;
        slow = 1'b0;
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_fixed();
        t_ignore();
        t_fifo();
        t_windows();
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        stop_test();
    end
endmodule : lpd_decoder_tb_top
`default_nettype wire
